// ### rtl/spi_pin_mode_select.sv
// Behaviour
// - Master drives master-out line from shift register MSB, MSB first.
// - Master-out is output as master; master-in is output as slave.
// - Slave-out is high impedance when disabled or unselected 4-wire slave.
// - 3-wire slave drives slave-out from shift MSB continuously.
// - Serial clock is driven only as master, taken as input otherwise.
// - 4-wire slave ignores serial clock while select is high.
// - Mode 00 is 3-wire, select unused, slave always selected.
// - Mode 01 is 4-wire with select as input choosing the slave.
// - Mode 01 master disables itself on select falling edge.
// - Mode 1x drives select as output at the low mode bit.
// - Select pin unmapped in 3-wire mode, mapped in every other mode.
// - Slave counts clock edges, after eight bits flags done and stores byte.
// - 4-wire slave resets bit counter on select falling edge.
// - Mode fault sets its flag and clears master and port enables.
// - Transfer-done flag set at every byte end, cleared by software.
`include "spi_pin_mode_regs.svh"

module spi_pin_mode_select (
	input wire logic i_sys_clk, // System clock, 10 MHz.
	input wire logic i_resetn, // Synchronous reset, active low.
	input wire logic i_link_sck, // Serial clock from an external master.
	// Control and status.
	input wire logic [1:0] i_select_mode_field, // Select mode field.
	input wire logic i_ctrl_wr, // Pulse: load the two enables below.
	input wire logic i_master_en, // Master enable value to load.
	input wire logic i_port_en, // Port enable value to load.
	output logic o_master_en, // Current master enable.
	output logic o_port_en, // Current port enable.
	output logic o_xfer_done_flag, // Sticky: a byte finished.
	input wire logic i_xfer_done_clr, // Pulse: clear the done flag.
	output logic o_mode_fault_flag, // Sticky: mode fault seen.
	input wire logic i_mode_fault_clr, // Pulse: clear the fault flag.
	output logic o_busy, // Master transfer in progress.
	// Transmit byte.
	input wire logic i_tx_valid, // Byte offered for sending.
	output logic o_tx_ready, // Transmit buffer is empty.
	input wire logic [7:0] i_tx_data, // Byte to send.
	// Received bytes.
	output logic o_rx_valid, // A received byte is waiting.
	input wire logic i_rx_ready, // Consumer takes the byte.
	output logic [7:0] o_rx_data, // Oldest received byte.
	// Pins.
	input wire logic i_mosi, // Master-out line level.
	output logic o_mosi, // Master-out drive value.
	output logic o_mosi_oe_n, // Master-out enable, low drives.
	input wire logic i_miso, // Master-in line level.
	output logic o_miso, // Slave-out drive value.
	output logic o_miso_oe_n, // Slave-out enable, low drives.
	output logic o_sck, // Serial clock drive value.
	output logic o_sck_oe_n, // Serial clock enable, low drives.
	input wire logic i_slave_select_n, // Select line level.
	output logic o_slave_select_n, // Select drive value.
	output logic o_slave_select_n_oe_n, // Select enable, low drives.
	output logic o_select_mapped // Select signal routed to its pin.
);
	localparam logic [`SCK_DIV_W-1:0] SCK_HALF = `SCK_DIV_W'(`SCK_HALF_CYC);

	spi_link_if lnk ();

	// Decoded mode.
	logic mode_3wire, mode_multi, mode_out;
	logic is_master, is_slave, slave_sel;

	// Control registers.
	logic master_en_r, master_en_nxt, port_en_r, port_en_nxt;
	logic done_flag_r, done_flag_nxt, fault_flag_r, fault_flag_nxt;
	logic tx_full_r, tx_full_nxt;
	spi_pin_mode_pkg::byte_t tx_buf_r, tx_buf_nxt;

	// Synchronisers.
	logic sel_s1_r, sel_s2_r, sel_prev_r, sel_fall;
	logic miso_s1_r, miso_s2_r;
	logic tgl_s1_r, tgl_s2_r, tgl_prev_r, slave_done;
	logic link_rst_n_r, link_rst_n_nxt;

	// Master sequencer.
	spi_pin_mode_pkg::master_st_e mst_r, mst_nxt;
	logic [`SCK_DIV_W-1:0] div_r, div_nxt;
	logic [`BIT_CNT_W-1:0] mbit_r, mbit_nxt;
	spi_pin_mode_pkg::byte_t msh_r, msh_nxt;
	logic master_done, master_start;

	// FIFO write side.
	logic fifo_wr_valid, fifo_wr_ready;
	spi_pin_mode_pkg::byte_t fifo_wr_data;

	// Mode decode from the select-mode field.
	assign mode_3wire = (i_select_mode_field == `SEL_MODE_3WIRE);
	assign mode_multi = (i_select_mode_field == `SEL_MODE_MULTI);
	assign mode_out = i_select_mode_field[`SEL_MODE_HI_BIT];
	assign is_master = port_en_r && master_en_r;
	assign is_slave = port_en_r && !master_en_r;
	// A slave is selected always in 3-wire or output modes, else by the pin.
	assign slave_sel = mode_3wire || mode_out || !sel_s2_r;

	// Select and master-in pin inputs pass two flip-flops before the system-clock logic looks at them.
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			sel_s1_r <= 1'b1;
			sel_s2_r <= 1'b1;
			sel_prev_r <= 1'b1;
			miso_s1_r <= 1'b0;
			miso_s2_r <= 1'b0;
			tgl_s1_r <= 1'b0;
			tgl_s2_r <= 1'b0;
			tgl_prev_r <= 1'b0;
		end else begin
			sel_s1_r <= i_slave_select_n;
			sel_s2_r <= sel_s1_r;
			sel_prev_r <= sel_s2_r;
			miso_s1_r <= i_miso;
			miso_s2_r <= miso_s1_r;
			// Clearing the link side drops its toggle to zero. The copies are cleared
			// with it, so that drop is never mistaken for a finished byte.
			tgl_s1_r <= link_rst_n_r && lnk.done_tgl;
			tgl_s2_r <= link_rst_n_r && tgl_s1_r;
			tgl_prev_r <= link_rst_n_r && tgl_s2_r;
		end
	end

	// Edges seen only on synchronised copies.
	assign sel_fall = sel_prev_r && !sel_s2_r;
	assign slave_done = tgl_s2_r ^ tgl_prev_r;

	// The link side is held cleared whenever it must not count: port off,
	// master role, or a 4-wire slave not selected. Releasing on the select
	// low level restarts the bit count at every select falling edge.
	always_comb begin
		link_rst_n_nxt = is_slave && slave_sel;
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			link_rst_n_r <= 1'b0;
		end else begin
			link_rst_n_r <= link_rst_n_nxt;
		end
	end

	assign lnk.link_rst_n = link_rst_n_r;
	assign lnk.tx_byte = tx_buf_r;

	spi_slave_shifter u_shifter (
		.i_link_sck(i_link_sck),
		.i_mosi(i_mosi),
		.lnk(lnk.link)
	);

	// Master sequencer: sck low half, then high half, taking the bit on the fall.
	// Starting waits for a free FIFO slot so no byte received as master is ever lost.
	assign master_start = is_master && tx_full_r && fifo_wr_ready;

	always_comb begin
		mst_nxt = mst_r;
		div_nxt = div_r;
		mbit_nxt = mbit_r;
		msh_nxt = msh_r;
		master_done = 1'b0;
		case (mst_r)
			spi_pin_mode_pkg::M_IDLE: begin
				div_nxt = SCK_HALF;
				mbit_nxt = `BIT_CNT_ZERO;
				if (master_start) begin
					msh_nxt = tx_buf_r;
					mst_nxt = spi_pin_mode_pkg::M_LOW;
				end
			end
			spi_pin_mode_pkg::M_LOW: begin
				div_nxt = div_r - 1'b1;
				if (div_r == `SCK_DIV_W'(1)) begin
					div_nxt = SCK_HALF;
					// Rising edge: the data line must stay still here for the slave.
					mst_nxt = spi_pin_mode_pkg::M_HIGH;
				end
			end
			spi_pin_mode_pkg::M_HIGH: begin
				div_nxt = div_r - 1'b1;
				if (div_r == `SCK_DIV_W'(1)) begin
					div_nxt = SCK_HALF;
					// Falling edge: take the bit seen in the high half, present the next.
					// The synchroniser lags two cycles, so a half needs three or more.
					msh_nxt = {msh_r[`BYTE_MSB-1:0], miso_s2_r};
					mbit_nxt = mbit_r + 1'b1;
					if (mbit_r == `BIT_CNT_LAST) begin
						master_done = 1'b1;
						mst_nxt = spi_pin_mode_pkg::M_IDLE;
					end else begin
						mst_nxt = spi_pin_mode_pkg::M_LOW;
					end
				end
			end
			default: begin
				mst_nxt = spi_pin_mode_pkg::M_IDLE;
			end
		endcase
		// Losing the master role drops any transfer at once.
		if (!is_master) begin
			mst_nxt = spi_pin_mode_pkg::M_IDLE;
			master_done = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			mst_r <= spi_pin_mode_pkg::M_IDLE;
			div_r <= SCK_HALF;
			mbit_r <= `BIT_CNT_ZERO;
			msh_r <= 8'h00;
		end else begin
			mst_r <= mst_nxt;
			div_r <= div_nxt;
			mbit_r <= mbit_nxt;
			msh_r <= msh_nxt;
		end
	end

	// Received byte goes to the FIFO: master byte, or slave holding register
	// that the toggle has just released. A slave byte meeting a full FIFO is
	// dropped, because an external master cannot be stalled.
	always_comb begin
		fifo_wr_valid = master_done || (slave_done && is_slave);
		fifo_wr_data = msh_nxt;
		if (!master_done) begin
			fifo_wr_data = tgl_s2_r ? lnk.rx_hold0 : lnk.rx_hold1;
		end
	end

	spi_rx_fifo #(
		.WIDTH(8),
		.DEPTH(`RX_FIFO_DEPTH),
		.AW(`RX_FIFO_AW)
	) u_fifo (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_wr_valid(fifo_wr_valid),
		.o_wr_ready(fifo_wr_ready),
		.i_wr_data(fifo_wr_data),
		.o_rd_valid(o_rx_valid),
		.i_rd_ready(i_rx_ready),
		.o_rd_data(o_rx_data)
	);

	// Control, flags and transmit buffer. Hardware sets win over software clears.
	always_comb begin
		master_en_nxt = master_en_r;
		port_en_nxt = port_en_r;
		if (i_ctrl_wr) begin
			master_en_nxt = i_master_en;
			port_en_nxt = i_port_en;
		end
		done_flag_nxt = done_flag_r && !i_xfer_done_clr;
		if (master_done || (slave_done && is_slave)) begin
			done_flag_nxt = 1'b1;
		end
		fault_flag_nxt = fault_flag_r && !i_mode_fault_clr;
		if (is_master && mode_multi && sel_fall) begin
			fault_flag_nxt = 1'b1;
			master_en_nxt = 1'b0;
			port_en_nxt = 1'b0;
		end
		tx_full_nxt = tx_full_r;
		tx_buf_nxt = tx_buf_r;
		// The buffer empties once the byte it held has left.
		if ((mst_r == spi_pin_mode_pkg::M_IDLE && master_start)
			|| (slave_done && is_slave)) begin
			tx_full_nxt = 1'b0;
		end
		if (i_tx_valid && o_tx_ready) begin
			tx_full_nxt = 1'b1;
			tx_buf_nxt = i_tx_data;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			master_en_r <= 1'b0;
			port_en_r <= 1'b0;
			done_flag_r <= 1'b0;
			fault_flag_r <= 1'b0;
			tx_full_r <= 1'b0;
			tx_buf_r <= 8'h00;
		end else begin
			master_en_r <= master_en_nxt;
			port_en_r <= port_en_nxt;
			done_flag_r <= done_flag_nxt;
			fault_flag_r <= fault_flag_nxt;
			tx_full_r <= tx_full_nxt;
			tx_buf_r <= tx_buf_nxt;
		end
	end

	assign o_tx_ready = !tx_full_r;
	assign o_master_en = master_en_r;
	assign o_port_en = port_en_r;
	assign o_xfer_done_flag = done_flag_r;
	assign o_mode_fault_flag = fault_flag_r;
	assign o_busy = (mst_r != spi_pin_mode_pkg::M_IDLE);

	// Pin drive. Enables are low while driving.
	assign o_mosi = msh_r[`BYTE_MSB];
	assign o_mosi_oe_n = !is_master;
	assign o_sck = (mst_r == spi_pin_mode_pkg::M_HIGH);
	assign o_sck_oe_n = !is_master;
	assign o_miso = lnk.miso_bit;
	// Slave-out floats when the port is off or a 4-wire slave is not chosen.
	assign o_miso_oe_n = !(is_slave && slave_sel);
	assign o_slave_select_n = i_select_mode_field[`SEL_MODE_LO_BIT];
	assign o_slave_select_n_oe_n = !mode_out;
	assign o_select_mapped = !mode_3wire;
endmodule

// ### rtl/spi_pin_mode_regs.svh
`ifndef SPI_PIN_MODE_REGS_SVH
`define SPI_PIN_MODE_REGS_SVH

// Encodings of the two-bit select-mode field.
`define SEL_MODE_3WIRE 2'h0
`define SEL_MODE_MULTI 2'h1
`define SEL_MODE_HI_BIT 1
`define SEL_MODE_LO_BIT 0

// Byte geometry and bit counter layout.
`define BYTE_BITS 8
`define BIT_CNT_W 3
`define BIT_CNT_LAST 3'h7
`define BIT_CNT_ZERO 3'h0
`define BYTE_MSB 7

// Receive FIFO shape.
`define RX_FIFO_DEPTH 32
`define RX_FIFO_AW 5

// Master serial clock timing: least half period, and the system clock period.
`define SYS_CLK_NS 100
`define SCK_HALF_NS 400
`define SCK_HALF_CYC ((`SCK_HALF_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define SCK_DIV_W 4

`endif

// ### rtl/spi_pin_mode_pkg.sv
package spi_pin_mode_pkg;

	// Master sequencer states, Gray coded along idle, low half, high half.
	typedef enum logic [1:0] {
		M_IDLE = 2'h0,
		M_LOW = 2'h1,
		M_HIGH = 2'h3
	} master_st_e;

	typedef logic [7:0] byte_t;

endpackage

// ### rtl/spi_link_if.sv
// Signals between the system-clock logic and the logic on the serial clock.
interface spi_link_if;
	logic link_rst_n;
	spi_pin_mode_pkg::byte_t tx_byte;
	spi_pin_mode_pkg::byte_t rx_hold0;
	spi_pin_mode_pkg::byte_t rx_hold1;
	logic done_tgl;
	logic miso_bit;

	modport sys (output link_rst_n, output tx_byte,
		input rx_hold0, input rx_hold1, input done_tgl, input miso_bit);
	modport link (input link_rst_n, input tx_byte,
		output rx_hold0, output rx_hold1, output done_tgl, output miso_bit);
endinterface

// ### rtl/spi_rx_fifo.sv
`include "spi_pin_mode_regs.svh"

// Synchronous FIFO with valid and ready on both sides.
module spi_rx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `RX_FIFO_DEPTH,
	parameter int AW = `RX_FIFO_AW
) (
	input wire logic i_sys_clk, // System clock.
	input wire logic i_resetn, // Synchronous reset, active low.
	input wire logic i_wr_valid, // Write request.
	output logic o_wr_ready, // Room for a word.
	input wire logic [WIDTH-1:0] i_wr_data, // Word written.
	output logic o_rd_valid, // A word is available.
	input wire logic i_rd_ready, // Drain side takes the word.
	output logic [WIDTH-1:0] o_rd_data // Oldest word.
);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
	logic [AW:0] count_r, count_nxt;
	logic do_wr, do_rd;

	// Full and empty come straight from the occupancy count.
	assign o_wr_ready = (count_r != (AW+1)'(DEPTH));
	assign o_rd_valid = (count_r != '0);
	assign o_rd_data = mem_r[rd_ptr_r];
	assign do_wr = i_wr_valid && o_wr_ready;
	assign do_rd = o_rd_valid && i_rd_ready;

	// Pointers wrap naturally because the depth is a power of two.
	always_comb begin
		wr_ptr_nxt = do_wr ? wr_ptr_r + 1'b1 : wr_ptr_r;
		rd_ptr_nxt = do_rd ? rd_ptr_r + 1'b1 : rd_ptr_r;
		count_nxt = count_r;
		if (do_wr && !do_rd) begin
			count_nxt = count_r + 1'b1;
		end else if (do_rd && !do_wr) begin
			count_nxt = count_r - 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r <= count_nxt;
		end
	end

	// Storage has no reset; it is only read once written.
	always_ff @(posedge i_sys_clk) begin
		if (do_wr) begin
			mem_r[wr_ptr_r] <= i_wr_data;
		end
	end
endmodule

// ### rtl/spi_slave_shifter.sv
`include "spi_pin_mode_regs.svh"

// Slave shifter running on the external serial clock, sampling on the rising edge.
module spi_slave_shifter (
	input wire logic i_link_sck, // Serial clock from the external master.
	input wire logic i_mosi, // Data from the master.
	spi_link_if.link lnk // Link to the system-clock side.
);
	logic [`BIT_CNT_W-1:0] cnt_r, cnt_nxt;
	spi_pin_mode_pkg::byte_t rx_sh_r, rx_sh_nxt, tx_sh_r, tx_sh_nxt;
	spi_pin_mode_pkg::byte_t hold0_r, hold0_nxt, hold1_r, hold1_nxt;
	logic tgl_r, tgl_nxt;

	// The serial clock stops between frames, so everything that must end
	// with a frame is cleared by the asynchronous link reset instead.
	always_comb begin
		rx_sh_nxt = {rx_sh_r[`BYTE_MSB-1:0], i_mosi};
		tx_sh_nxt = (cnt_r == `BIT_CNT_ZERO) ? {lnk.tx_byte[`BYTE_MSB-1:0], 1'b0}
			: {tx_sh_r[`BYTE_MSB-1:0], 1'b0};
		cnt_nxt = cnt_r + 1'b1;
		hold0_nxt = hold0_r;
		hold1_nxt = hold1_r;
		tgl_nxt = tgl_r;
		if (cnt_r == `BIT_CNT_LAST) begin
			// Alternate holding registers so each byte stays still for two bytes.
			if (tgl_r) begin
				hold1_nxt = rx_sh_nxt;
			end else begin
				hold0_nxt = rx_sh_nxt;
			end
			tgl_nxt = !tgl_r;
		end
	end

	always_ff @(posedge i_link_sck or negedge lnk.link_rst_n) begin
		if (!lnk.link_rst_n) begin
			cnt_r <= `BIT_CNT_ZERO;
			rx_sh_r <= 8'h00;
			tx_sh_r <= 8'h00;
			hold0_r <= 8'h00;
			hold1_r <= 8'h00;
			tgl_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			rx_sh_r <= rx_sh_nxt;
			tx_sh_r <= tx_sh_nxt;
			hold0_r <= hold0_nxt;
			hold1_r <= hold1_nxt;
			tgl_r <= tgl_nxt;
		end
	end

	// The outgoing bit is the shift register MSB, or the waiting byte's MSB
	// before the first edge of a byte.
	assign lnk.miso_bit = (cnt_r == `BIT_CNT_ZERO) ? lnk.tx_byte[`BYTE_MSB]
		: tx_sh_r[`BYTE_MSB];
	assign lnk.rx_hold0 = hold0_r;
	assign lnk.rx_hold1 = hold1_r;
	assign lnk.done_tgl = tgl_r;
endmodule

// ### dv/spi_far_end.sv
// Behavioural far-end device: a slave that echoes, or a master on its own link clock.
module spi_far_end (
	input wire logic i_sck, // Clock line.
	input wire logic i_mosi, // Master-out line.
	input wire logic i_miso, // Master-in line.
	output logic o_sck, // Clock as master.
	output logic o_mosi, // Data as master.
	output logic o_sel_n, // Select as master.
	output logic o_miso // Data as slave.
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] s_sh = 8'h00;
	logic [7:0] s_rx = 8'h00;

	initial begin
		o_sck = 1'b0;
		o_mosi = 1'b0;
		o_sel_n = 1'b1;
	end

	// Samples on the rise, shifts on the fall, so a second byte returns the first.
	always @(posedge i_sck) s_rx <= {s_rx[6:0], i_mosi};
	always @(negedge i_sck) s_sh <= {s_sh[6:0], s_rx[0]};
	assign o_miso = s_sh[7];

	// The clock stands low outside frames; a released data line shows the inverse.
	task automatic xfer(input logic [7:0] t, input logic s, input int n, output logic [7:0] r);
		r = 8'h00;
		o_sel_n = !s;
		#400;
		for (int i = 0; i < n; i++) begin
			o_mosi = t[7 - i];
			#16;
			r = {r[6:0], i_miso};
			o_sck = 1'b1;
			#16;
			o_sck = 1'b0;
		end
		#16;
		o_mosi = !o_mosi;
		o_sel_n = 1'b1;
		#600;
	endtask
endmodule

// ### dv/spi_pin_mode_select_asserts.sv
module spi_pin_mode_select_asserts (
	input wire logic i_sys_clk, // Clock.
	input wire logic i_resetn, // Reset.
	input wire logic [1:0] i_select_mode_field, // Mode.
	input wire logic i_tx_valid, // Offer.
	input wire logic o_tx_ready, // Empty.
	input wire logic [7:0] i_tx_data, // Byte.
	input wire logic o_master_en, // Master.
	input wire logic o_port_en, // Enable.
	input wire logic o_mode_fault_flag, // Fault.
	input wire logic o_xfer_done_flag, // Done.
	input wire logic o_busy, // Busy.
	input wire logic o_mosi, // Data.
	input wire logic o_mosi_oe_n, // Enable.
	input wire logic o_miso_oe_n, // Enable.
	input wire logic o_sck, // Clock.
	input wire logic i_slave_select_n, // Select.
	input wire logic o_slave_select_n, // Select.
	input wire logic o_slave_select_n_oe_n, // Enable.
	input wire logic o_select_mapped // Mapped.
);
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_resetn);
	logic [7:0] tx_cap_r;
	logic [7:0] tx_cap_nxt;

	// Byte last taken into the transmit buffer, to know what the first bit must be.
	always_comb begin
		tx_cap_nxt = tx_cap_r;
		if (i_tx_valid && o_tx_ready) tx_cap_nxt = i_tx_data;
	end
	always_ff @(posedge i_sys_clk) tx_cap_r <= i_resetn ? tx_cap_nxt : 8'h00;

	chk_mosi_msb: assert property ($rose(o_busy) |-> o_mosi == tx_cap_r[7])
		else $error("first bit out is not the MSB");
	chk_mosi_out: assert property ((o_master_en && o_port_en) [*2] |-> !o_mosi_oe_n)
		else $error("master not driving data out");
	chk_miso_off: assert property ((!o_port_en) [*2] |-> o_miso_oe_n)
		else $error("slave out driven while disabled");
	chk_miso_unsel: assert property ((i_select_mode_field == 2'h1 && i_slave_select_n
		&& !o_master_en) [*5] |-> o_miso_oe_n) else $error("unselected slave drives");
	chk_miso_3w: assert property ((i_select_mode_field == 2'h0 && o_port_en
		&& !o_master_en) [*2] |-> !o_miso_oe_n) else $error("3-wire slave not driving");
	chk_sck_idle: assert property (!o_busy |-> !o_sck)
		else $error("clock not idle low");
	chk_fault_set: assert property (i_select_mode_field == 2'h1 && o_master_en
		&& $fell(i_slave_select_n) |-> ##[1:5] o_mode_fault_flag) else $error("no fault");
	chk_fault_off: assert property ($rose(o_mode_fault_flag) |-> !o_master_en && !o_port_en)
		else $error("enables kept on fault");
	chk_sel_out: assert property (i_select_mode_field[1] |-> !o_slave_select_n_oe_n
		&& o_slave_select_n == i_select_mode_field[0]) else $error("select out wrong");
	chk_sel_map: assert property (o_select_mapped == (i_select_mode_field != 2'h0))
		else $error("select mapping wrong");
	chk_done_set: assert property ($fell(o_busy) && o_master_en && o_port_en
		|-> o_xfer_done_flag) else $error("done flag not set");
endmodule

bind spi_pin_mode_select spi_pin_mode_select_asserts u_chk (.i_sys_clk, .i_resetn,
	.i_select_mode_field, .i_tx_valid, .o_tx_ready, .i_tx_data, .o_master_en, .o_port_en,
	.o_mode_fault_flag, .o_xfer_done_flag, .o_busy, .o_mosi, .o_mosi_oe_n, .o_miso_oe_n,
	.o_sck, .i_slave_select_n, .o_slave_select_n, .o_slave_select_n_oe_n, .o_select_mapped);

// ### dv/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LIM = 400;
	logic i_sys_clk = 1'b0, i_resetn = 1'b0, i_ctrl_wr = 1'b0, i_master_en = 1'b0;
	logic i_port_en = 1'b0, i_xfer_done_clr = 1'b0, i_mode_fault_clr = 1'b0;
	logic i_tx_valid = 1'b0, i_rx_ready = 1'b0;
	logic [1:0] i_select_mode_field = 2'h0;
	logic [7:0] i_tx_data = 8'h00, o_rx_data, rb;
	logic o_master_en, o_port_en, o_xfer_done_flag, o_mode_fault_flag, o_busy, o_tx_ready;
	logic o_rx_valid, o_mosi, o_mosi_oe_n, o_miso, o_miso_oe_n, o_sck, o_sck_oe_n;
	logic o_slave_select_n, o_slave_select_n_oe_n, o_select_mapped, m_sck, m_mosi, m_sel_n, s_miso;
	wire logic i_link_sck, i_mosi, i_miso, i_slave_select_n;
	int n_fail = 0, tests_run = 0, k;

	// Each line carries whichever party has its enable low.
	assign i_link_sck = !o_sck_oe_n ? o_sck : m_sck;
	assign i_mosi = !o_mosi_oe_n ? o_mosi : m_mosi;
	assign i_miso = !o_miso_oe_n ? o_miso : s_miso;
	assign i_slave_select_n = !o_slave_select_n_oe_n ? o_slave_select_n : m_sel_n;
	always #50 i_sys_clk = !i_sys_clk;

	spi_pin_mode_select dut (.i_sys_clk, .i_resetn, .i_link_sck, .i_select_mode_field,
		.i_ctrl_wr, .i_master_en, .i_port_en, .o_master_en, .o_port_en, .o_xfer_done_flag,
		.i_xfer_done_clr, .o_mode_fault_flag, .i_mode_fault_clr, .o_busy, .i_tx_valid,
		.o_tx_ready, .i_tx_data, .o_rx_valid, .i_rx_ready, .o_rx_data, .i_mosi, .o_mosi,
		.o_mosi_oe_n, .i_miso, .o_miso, .o_miso_oe_n, .o_sck, .o_sck_oe_n,
		.i_slave_select_n, .o_slave_select_n, .o_slave_select_n_oe_n, .o_select_mapped);
	spi_far_end far (.i_sck(i_link_sck), .i_mosi, .i_miso, .o_sck(m_sck), .o_mosi(m_mosi),
		.o_sel_n(m_sel_n), .o_miso(s_miso));

	task test_done();
		$display("checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// A wait that used up its bound ends the run.
	task lim(input string nm);
		if (k >= LIM) begin
			n_fail++;
			$display("[ERR] %s expected 1 seen timeout", nm);
			test_done();
		end
	endtask
	// All tasks below start and end on a falling edge.
	task ctrl(input logic m, input logic p);
		i_master_en = m;
		i_port_en = p;
		i_ctrl_wr = 1'b1;
		@(negedge i_sys_clk);
		i_ctrl_wr = 1'b0;
		@(negedge i_sys_clk);
	endtask
	task push(input logic [7:0] d);
		for (k = 0; k < LIM && o_tx_ready !== 1'b1; k++) @(negedge i_sys_clk);
		lim("tx_ready");
		i_tx_valid = 1'b1;
		i_tx_data = d;
		@(negedge i_sys_clk);
		i_tx_valid = 1'b0;
	endtask
	task pop(input logic [7:0] e);
		for (k = 0; k < LIM && o_rx_valid !== 1'b1; k++) @(negedge i_sys_clk);
		lim("rx_valid");
		chk("rx_data", e, o_rx_data);
		i_rx_ready = 1'b1;
		@(negedge i_sys_clk);
		i_rx_ready = 1'b0;
		@(negedge i_sys_clk);
	endtask
	task wdone();
		for (k = 0; k < LIM && o_xfer_done_flag !== 1'b1; k++) @(negedge i_sys_clk);
		lim("done");
	endtask
	task clr_done();
		i_xfer_done_clr = 1'b1;
		@(negedge i_sys_clk);
		i_xfer_done_clr = 1'b0;
		@(negedge i_sys_clk);
		chk("done_clr", 8'h00, o_xfer_done_flag);
	endtask
	task sx(input logic [7:0] t, input logic s, input int n);
		far.xfer(t, s, n, rb);
		@(negedge i_sys_clk);
	endtask

	initial begin
		repeat (8) @(negedge i_sys_clk);
		i_resetn = 1'b1;
		@(negedge i_sys_clk);
		chk("miso_oe", 8'h01, o_miso_oe_n);
		chk("sck_oe", 8'h01, o_sck_oe_n);
		ctrl(1'b1, 1'b1);
		chk("mosi_oe", 8'h00, o_mosi_oe_n);
		chk("miso_oe", 8'h01, o_miso_oe_n);
		chk("sck_oe", 8'h00, o_sck_oe_n);
		for (int m = 0; m < 4; m++) begin
			i_select_mode_field = m[1:0];
			@(negedge i_sys_clk);
			chk("mapped", m != 0, o_select_mapped);
			chk("sel_oe", !m[1], o_slave_select_n_oe_n);
			if (m[1]) chk("sel_out", m[0], o_slave_select_n);
		end
		// Master, 3-wire, two bytes back to back against an echoing slave.
		i_select_mode_field = 2'h0;
		far.s_sh = 8'h5A;
		push(8'hA5);
		push(8'h3C);
		wdone();
		chk("far_rx0", 8'hA5, far.s_rx);
		clr_done();
		wdone();
		chk("far_rx1", 8'h3C, far.s_rx);
		pop(8'h5A);
		pop(8'hA5);
		clr_done();
		// Another master pulls select low in multi-master mode.
		i_select_mode_field = 2'h1;
		repeat (4) @(negedge i_sys_clk);
		far.o_sel_n = 1'b0;
		for (k = 0; k < LIM && o_mode_fault_flag !== 1'b1; k++) @(negedge i_sys_clk);
		lim("fault");
		chk("master_en", 8'h00, o_master_en);
		chk("port_en", 8'h00, o_port_en);
		far.o_sel_n = 1'b1;
		i_mode_fault_clr = 1'b1;
		@(negedge i_sys_clk);
		i_mode_fault_clr = 1'b0;
		@(negedge i_sys_clk);
		chk("fault_clr", 8'h00, o_mode_fault_flag);
		// 4-wire slave: clocks while unselected are ignored, a cut byte is forgotten.
		ctrl(1'b0, 1'b1);
		repeat (4) @(negedge i_sys_clk);
		chk("miso_oe", 8'h01, o_miso_oe_n);
		push(8'hC3);
		sx(8'hFF, 1'b0, 8);
		repeat (6) @(negedge i_sys_clk);
		chk("rx_valid", 8'h00, o_rx_valid);
		sx(8'h96, 1'b1, 8);
		chk("miso_tx", 8'hC3, rb);
		pop(8'h96);
		chk("done", 8'h01, o_xfer_done_flag);
		sx(8'hE0, 1'b1, 3);
		sx(8'h4B, 1'b1, 8);
		pop(8'h4B);
		// 3-wire slave fills the receive buffer; the byte beyond it is dropped.
		ctrl(1'b0, 1'b0);
		i_select_mode_field = 2'h0;
		ctrl(1'b0, 1'b1);
		chk("miso_oe", 8'h00, o_miso_oe_n);
		for (int i = 0; i < 33; i++) sx(i[7:0], 1'b0, 8);
		for (int i = 0; i < 32; i++) pop(i[7:0]);
		repeat (4) @(negedge i_sys_clk);
		chk("rx_empty", 8'h00, o_rx_valid);
		test_done();
	end
endmodule
